// file: core/acc_pkg.sv
// package: register map, field layout and types of the channel config bank
package acc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] ADDR_CHANNEL_CONFIG = 8'h18;
  localparam logic [7:0] ADDR_OFFSET_CAL_HIGH = 8'h19;
  localparam logic [7:0] ADDR_OFFSET_CAL_LOW = 8'h1A;
  localparam logic [7:0] ADDR_GAIN_CAL_HIGH = 8'h1B;
  localparam logic [7:0] ADDR_GAIN_CAL_LOW = 8'h1C;
  localparam logic [15:0] RST_CHANNEL_CONFIG = 16'h0000;
  localparam logic [15:0] RST_OFFSET_CAL_HIGH = 16'h0000;
  localparam logic [15:0] RST_OFFSET_CAL_LOW = 16'h0000;
  localparam logic [15:0] RST_GAIN_CAL_HIGH = 16'h8000;
  localparam logic [15:0] RST_GAIN_CAL_LOW = 16'h0000;
  localparam logic [15:0] RD_ZERO = 16'h0000;
  // writable bits of each register; all others are reserved
  localparam logic [15:0] MASK_CONFIG = 16'hFFC7;
  localparam logic [15:0] MASK_FULL = 16'hFFFF;
  localparam logic [15:0] MASK_LOW = 16'hFF00;
  localparam int PHASE_HI = 15;
  localparam int PHASE_LO = 6;
  localparam int DCOFF_BIT = 2;
  localparam int SEL_HI = 1;
  localparam int SEL_LO = 0;
  localparam int LOW_HI = 15;
  localparam int LOW_LO = 8;
  localparam logic [1:0] SEL_ANALOG = 2'h0;
  localparam logic [1:0] SEL_SHORT = 2'h1;
  localparam logic [1:0] SEL_POS_TEST = 2'h2;
  localparam logic [1:0] SEL_NEG_TEST = 2'h3;

  typedef enum logic [1:0] {
    ACC_IN_ANALOG,
    ACC_IN_SHORT,
    ACC_IN_POS_TEST,
    ACC_IN_NEG_TEST
  } acc_input_e;

  typedef struct packed {
    logic [15:0] channel_config;
    logic [15:0] offset_cal_high;
    logic [15:0] offset_cal_low;
    logic [15:0] gain_cal_high;
    logic [15:0] gain_cal_low;
    logic [15:0] rdata;
    logic dc_active;
  } acc_state_s;

  typedef struct packed {
    logic signed [9:0] phase_delay;
    logic dc_filter_off;
    logic [1:0] input_select;
    logic signed [23:0] offset_cal;
    logic [23:0] gain_cal;
  } acc_cal_s;
endpackage

// file: core/acc_regs.sv
// channel configuration and calibration register bank with plain register port
// Overview of operation
// [RULE1] config bits 15:6 hold a signed 10-bit phase delay in modulator clock cycles.
// [RULE2] config bit 2 low leaves DC blocking to the global setting, high turns it off here.
// [RULE3] config bits 1:0 pick analog pins, shorted inputs, positive or negative test signal.
// [RULE4] the whole high offset register holds offset bits 23:8 of a signed 24-bit value.
// [RULE5] low offset register bits 15:8 hold offset bits 7:0, completing the signed offset.
// [RULE6] the gain correction is a 24-bit unsigned value spanning zero to just below two.
// [RULE7] the whole high gain register holds gain bits 23:8.
// [RULE8] low gain register bits 15:8 hold gain bits 7:0, completing the unsigned gain.
// [RULE9] the high gain register resets to 8000h so the gain starts at unity.
// [RULE10] the config register resets to all zeros.
// [RULE11] reserved bits read as zero and ignore writes.
`timescale 1ns/10ps
module acc_regs (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic GLOBAL_DC_FILTER_SETTING,
  output logic [15:0] RDATA,
  output logic signed [9:0] PHASE_DELAY,
  output logic DC_FILTER_ACTIVE,
  output logic [1:0] INPUT_SELECT,
  output logic signed [23:0] OFFSET_CAL,
  output logic [23:0] GAIN_CAL
);
  acc_pkg::acc_state_s state_r;
  acc_pkg::acc_state_s state_nxt;

  always_comb begin
    state_nxt = state_r;
    state_nxt.rdata = acc_pkg::RD_ZERO;
    if (WR) begin
      if (ADDR == acc_pkg::ADDR_CHANNEL_CONFIG) begin
        state_nxt.channel_config = WDATA & acc_pkg::MASK_CONFIG; // [RULE1] [RULE2] [RULE3] [RULE11]
      end else if (ADDR == acc_pkg::ADDR_OFFSET_CAL_HIGH) begin
        state_nxt.offset_cal_high = WDATA & acc_pkg::MASK_FULL; // [RULE4]
      end else if (ADDR == acc_pkg::ADDR_OFFSET_CAL_LOW) begin
        state_nxt.offset_cal_low = WDATA & acc_pkg::MASK_LOW; // [RULE5] [RULE11]
      end else if (ADDR == acc_pkg::ADDR_GAIN_CAL_HIGH) begin
        state_nxt.gain_cal_high = WDATA & acc_pkg::MASK_FULL; // [RULE7]
      end else if (ADDR == acc_pkg::ADDR_GAIN_CAL_LOW) begin
        state_nxt.gain_cal_low = WDATA & acc_pkg::MASK_LOW; // [RULE8] [RULE11]
      end
    end
    if (RD) begin
      if (ADDR == acc_pkg::ADDR_CHANNEL_CONFIG) begin
        state_nxt.rdata = state_r.channel_config;
      end else if (ADDR == acc_pkg::ADDR_OFFSET_CAL_HIGH) begin
        state_nxt.rdata = state_r.offset_cal_high;
      end else if (ADDR == acc_pkg::ADDR_OFFSET_CAL_LOW) begin
        state_nxt.rdata = state_r.offset_cal_low;
      end else if (ADDR == acc_pkg::ADDR_GAIN_CAL_HIGH) begin
        state_nxt.rdata = state_r.gain_cal_high;
      end else if (ADDR == acc_pkg::ADDR_GAIN_CAL_LOW) begin
        state_nxt.rdata = state_r.gain_cal_low;
      end else begin
        state_nxt.rdata = acc_pkg::RD_ZERO;
      end
    end
    // filter runs only when the global setting enables it and this channel does not veto
    state_nxt.dc_active = GLOBAL_DC_FILTER_SETTING &
                          ~state_nxt.channel_config[acc_pkg::DCOFF_BIT]; // [RULE2]
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r.channel_config <= acc_pkg::RST_CHANNEL_CONFIG; // [RULE10]
      state_r.offset_cal_high <= acc_pkg::RST_OFFSET_CAL_HIGH;
      state_r.offset_cal_low <= acc_pkg::RST_OFFSET_CAL_LOW;
      state_r.gain_cal_high <= acc_pkg::RST_GAIN_CAL_HIGH; // [RULE9]
      state_r.gain_cal_low <= acc_pkg::RST_GAIN_CAL_LOW;
      state_r.rdata <= acc_pkg::RD_ZERO;
      state_r.dc_active <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign RDATA = state_r.rdata;
  assign PHASE_DELAY = state_r.channel_config[acc_pkg::PHASE_HI:acc_pkg::PHASE_LO]; // [RULE1]
  assign DC_FILTER_ACTIVE = state_r.dc_active;
  assign INPUT_SELECT = state_r.channel_config[acc_pkg::SEL_HI:acc_pkg::SEL_LO]; // [RULE3]
  assign OFFSET_CAL = {state_r.offset_cal_high,
                       state_r.offset_cal_low[acc_pkg::LOW_HI:acc_pkg::LOW_LO]}; // [RULE4] [RULE5]
  assign GAIN_CAL = {state_r.gain_cal_high,
                     state_r.gain_cal_low[acc_pkg::LOW_HI:acc_pkg::LOW_LO]}; // [RULE6] [RULE7] [RULE8]

  property p_cfg_write;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == acc_pkg::ADDR_CHANNEL_CONFIG) |=>
        (PHASE_DELAY == $past(WDATA[15:6]) && INPUT_SELECT == $past(WDATA[1:0]));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write not stored"); // [RULE1]

  property p_dc_filter;
    @(posedge SYS_CLK) disable iff (!RST_B)
      ##1 (DC_FILTER_ACTIVE == ($past(GLOBAL_DC_FILTER_SETTING) &&
           !state_r.channel_config[acc_pkg::DCOFF_BIT]));
  endproperty
  a_dc_filter: assert property (p_dc_filter) else $error("dc filter control wrong"); // [RULE2]

  property p_sel_hold;
    @(posedge SYS_CLK) disable iff (!RST_B)
      !(WR && ADDR == acc_pkg::ADDR_CHANNEL_CONFIG) |=> $stable(INPUT_SELECT);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("input select changed"); // [RULE3]

  property p_offset;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == acc_pkg::ADDR_OFFSET_CAL_HIGH) |=> OFFSET_CAL[23:8] == $past(WDATA);
  endproperty
  a_offset: assert property (p_offset) else $error("offset high not stored"); // [RULE4]

  property p_offset_low;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == acc_pkg::ADDR_OFFSET_CAL_LOW) |=> OFFSET_CAL[7:0] == $past(WDATA[15:8]);
  endproperty
  a_offset_low: assert property (p_offset_low) else $error("offset low not stored"); // [RULE5]

  property p_gain;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == acc_pkg::ADDR_GAIN_CAL_HIGH) |=> GAIN_CAL[23:8] == $past(WDATA);
  endproperty
  a_gain: assert property (p_gain) else $error("gain high not stored"); // [RULE7]

  property p_gain_low;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == acc_pkg::ADDR_GAIN_CAL_LOW) |=> GAIN_CAL[7:0] == $past(WDATA[15:8]);
  endproperty
  a_gain_low: assert property (p_gain_low) else $error("gain low not stored"); // [RULE8]

  property p_gain_reset;
    @(posedge SYS_CLK) $rose(RST_B) |-> GAIN_CAL == 24'h800000;
  endproperty
  a_gain_reset: assert property (p_gain_reset) else $error("gain not unity at reset"); // [RULE9]

  property p_cfg_reset;
    @(posedge SYS_CLK) $rose(RST_B) |-> (PHASE_DELAY == 10'h000 && INPUT_SELECT == 2'h0);
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config not zero at reset"); // [RULE10]

  property p_reserved;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (RD && (ADDR == acc_pkg::ADDR_OFFSET_CAL_LOW || ADDR == acc_pkg::ADDR_GAIN_CAL_LOW))
        |=> RDATA[7:0] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // [RULE11]

  property p_cfg_reserved;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (RD && ADDR == acc_pkg::ADDR_CHANNEL_CONFIG) |=> RDATA[5:3] == 3'h0;
  endproperty
  a_cfg_reserved: assert property (p_cfg_reserved) else $error("config reserved nonzero"); // [RULE11]

  // read data must mirror the fields that the outputs already show
  property p_rd_cfg;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (RD && ADDR == acc_pkg::ADDR_CHANNEL_CONFIG) |=>
        RDATA[acc_pkg::PHASE_HI:acc_pkg::PHASE_LO] == $past(PHASE_DELAY);
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config read phase wrong"); // [RULE1]

  property p_rd_sel;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (RD && ADDR == acc_pkg::ADDR_CHANNEL_CONFIG) |=>
        RDATA[acc_pkg::SEL_HI:acc_pkg::SEL_LO] == $past(INPUT_SELECT);
  endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("config read select wrong"); // [RULE3]

  property p_rd_ocal_hi;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (RD && ADDR == acc_pkg::ADDR_OFFSET_CAL_HIGH) |=>
        RDATA == $past(OFFSET_CAL[23:8]);
  endproperty
  a_rd_ocal_hi: assert property (p_rd_ocal_hi) else $error("offset high read wrong"); // [RULE4]

  property p_rd_ocal_lo;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (RD && ADDR == acc_pkg::ADDR_OFFSET_CAL_LOW) |=>
        RDATA[acc_pkg::LOW_HI:acc_pkg::LOW_LO] == $past(OFFSET_CAL[7:0]);
  endproperty
  a_rd_ocal_lo: assert property (p_rd_ocal_lo) else $error("offset low read wrong"); // [RULE5]

  property p_rd_gcal_hi;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (RD && ADDR == acc_pkg::ADDR_GAIN_CAL_HIGH) |=>
        RDATA == $past(GAIN_CAL[23:8]);
  endproperty
  a_rd_gcal_hi: assert property (p_rd_gcal_hi) else $error("gain high read wrong"); // [RULE7]

  property p_rd_gcal_lo;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (RD && ADDR == acc_pkg::ADDR_GAIN_CAL_LOW) |=>
        RDATA[acc_pkg::LOW_HI:acc_pkg::LOW_LO] == $past(GAIN_CAL[7:0]);
  endproperty
  a_rd_gcal_lo: assert property (p_rd_gcal_lo) else $error("gain low read wrong"); // [RULE8]

  property p_rd_unmapped;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (RD && (ADDR < acc_pkg::ADDR_CHANNEL_CONFIG || ADDR > acc_pkg::ADDR_GAIN_CAL_LOW)) |=>
        RDATA == acc_pkg::RD_ZERO;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero"); // [RULE11]

  // read data stands for one cycle only
  property p_rd_idle;
    @(posedge SYS_CLK) disable iff (!RST_B)
      !RD |=>
        RDATA == acc_pkg::RD_ZERO;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");

  property p_dc_veto;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == acc_pkg::ADDR_CHANNEL_CONFIG && WDATA[acc_pkg::DCOFF_BIT]) |=>
        !DC_FILTER_ACTIVE;
  endproperty
  a_dc_veto: assert property (p_dc_veto) else $error("channel veto ignored"); // [RULE2]

  property p_dc_global_off;
    @(posedge SYS_CLK) disable iff (!RST_B)
      !GLOBAL_DC_FILTER_SETTING |=>
        !DC_FILTER_ACTIVE;
  endproperty
  a_dc_global_off: assert property (p_dc_global_off) else $error("filter on while off"); // [RULE2]

  property p_phase_hold;
    @(posedge SYS_CLK) disable iff (!RST_B)
      !(WR && ADDR == acc_pkg::ADDR_CHANNEL_CONFIG) |=>
        $stable(PHASE_DELAY);
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("phase changed"); // [RULE1]

  property p_phase_sign;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == acc_pkg::ADDR_CHANNEL_CONFIG) |=>
        (PHASE_DELAY < 0) == $past(WDATA[acc_pkg::PHASE_HI]);
  endproperty
  a_phase_sign: assert property (p_phase_sign) else $error("phase sign wrong"); // [RULE1]

  property p_ocal_hold;
    @(posedge SYS_CLK) disable iff (!RST_B)
      !(WR && (ADDR == acc_pkg::ADDR_OFFSET_CAL_HIGH || ADDR == acc_pkg::ADDR_OFFSET_CAL_LOW)) |=>
        $stable(OFFSET_CAL);
  endproperty
  a_ocal_hold: assert property (p_ocal_hold) else $error("offset changed"); // [RULE4]

  property p_gcal_hold;
    @(posedge SYS_CLK) disable iff (!RST_B)
      !(WR && (ADDR == acc_pkg::ADDR_GAIN_CAL_HIGH || ADDR == acc_pkg::ADDR_GAIN_CAL_LOW)) |=>
        $stable(GAIN_CAL);
  endproperty
  a_gcal_hold: assert property (p_gcal_hold) else $error("gain changed"); // [RULE6]

  // the halves of each 24-bit value update independently
  property p_ocal_hi_only;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == acc_pkg::ADDR_OFFSET_CAL_HIGH) |=>
        OFFSET_CAL[7:0] == $past(OFFSET_CAL[7:0]);
  endproperty
  a_ocal_hi_only: assert property (p_ocal_hi_only) else $error("offset low disturbed"); // [RULE5]

  property p_ocal_lo_only;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == acc_pkg::ADDR_OFFSET_CAL_LOW) |=>
        OFFSET_CAL[23:8] == $past(OFFSET_CAL[23:8]);
  endproperty
  a_ocal_lo_only: assert property (p_ocal_lo_only) else $error("offset high disturbed"); // [RULE4]

  property p_gcal_hi_only;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == acc_pkg::ADDR_GAIN_CAL_HIGH) |=>
        GAIN_CAL[7:0] == $past(GAIN_CAL[7:0]);
  endproperty
  a_gcal_hi_only: assert property (p_gcal_hi_only) else $error("gain low disturbed"); // [RULE8]

  property p_gcal_lo_only;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == acc_pkg::ADDR_GAIN_CAL_LOW) |=>
        GAIN_CAL[23:8] == $past(GAIN_CAL[23:8]);
  endproperty
  a_gcal_lo_only: assert property (p_gcal_lo_only) else $error("gain high disturbed"); // [RULE7]

  property p_unmapped_wr;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (WR && (ADDR < acc_pkg::ADDR_CHANNEL_CONFIG || ADDR > acc_pkg::ADDR_GAIN_CAL_LOW)) |=>
        ($stable(GAIN_CAL) && $stable(OFFSET_CAL) && $stable(PHASE_DELAY) && $stable(INPUT_SELECT));
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write took effect"); // [RULE11]

  property p_rst_misc;
    @(posedge SYS_CLK)
      $rose(RST_B) |->
        (!DC_FILTER_ACTIVE && RDATA == acc_pkg::RD_ZERO && OFFSET_CAL == 24'h000000);
  endproperty
  a_rst_misc: assert property (p_rst_misc) else $error("outputs not clear at reset"); // [RULE10]

  property p_cfg_res_state;
    @(posedge SYS_CLK) disable iff (!RST_B)
      1'b1 |->
        (state_r.channel_config & ~acc_pkg::MASK_CONFIG) == acc_pkg::RD_ZERO;
  endproperty
  a_cfg_res_state: assert property (p_cfg_res_state) else $error("config reserved held"); // [RULE11]

  property p_low_res_state;
    @(posedge SYS_CLK) disable iff (!RST_B)
      1'b1 |->
        ((state_r.offset_cal_low | state_r.gain_cal_low) & ~acc_pkg::MASK_LOW) == acc_pkg::RD_ZERO;
  endproperty
  a_low_res_state: assert property (p_low_res_state) else $error("low reserved held"); // [RULE11]
endmodule

// file: testbench/test_acc_regs.sv
// self-checking bench for the channel config and calibration register bank
`timescale 1ns/10ps
module test_acc_regs;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic gdc = 1'b0;
  logic [15:0] rdata;
  logic signed [9:0] phase_delay;
  logic dc_filter_active;
  logic [1:0] input_select;
  logic signed [23:0] offset_cal;
  logic [23:0] gain_cal;
  logic [15:0] sh [5];
  logic [23:0] corner [12] = '{24'h18FFFF, 24'h188000, 24'h180001, 24'h180002,
    24'h180003, 24'h198000, 24'h1AFFFF, 24'h1BFFFF, 24'h1CFF00, 24'h1C00FF,
    24'h1DFFFF, 24'h17FFFF};
  logic [7:0] a;
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 91286;
  int idx;

  always #2 sys_clk = ~sys_clk;

  acc_regs dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .GLOBAL_DC_FILTER_SETTING(gdc), .RDATA(rdata), .PHASE_DELAY(phase_delay),
    .DC_FILTER_ACTIVE(dc_filter_active), .INPUT_SELECT(input_select),
    .OFFSET_CAL(offset_cal), .GAIN_CAL(gain_cal));

  task give_verdict;
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one bus cycle, driven just after the edge
  task op(input logic w, input logic r, input logic [7:0] ad, input logic [15:0] d);
    @(posedge sys_clk);
    wr <= w;
    rd <= r;
    addr <= ad;
    wdata <= d;
  endtask

  function automatic logic [15:0] wmask(input logic [7:0] ad);
    case (ad)
      8'h18: wmask = 16'hFFC7;
      8'h19, 8'h1B: wmask = 16'hFFFF;
      8'h1A, 8'h1C: wmask = 16'hFF00;
      default: wmask = 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] exp_rd(input logic [7:0] ad);
    exp_rd = (ad inside {[8'h18:8'h1C]}) ? sh[ad - 8'h18] : 16'h0000;
  endfunction

  task reset_sh;
    sh = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
  endtask

  task outs;
    chk("phase_delay", phase_delay[9:0], sh[0][15:6]);
    chk("dc_filter_active", dc_filter_active, gdc & ~sh[0][2]);
    chk("input_select", input_select, sh[0][1:0]);
    chk("offset_cal", offset_cal, {sh[1], sh[2][15:8]});
    chk("gain_cal", gain_cal, {sh[3], sh[4][15:8]});
  endtask

  task rd_all;
    for (int i = 0; i < 5; i++) begin
      op(1'b0, 1'b1, 8'h18 + 8'(i), 16'h0000);
      op(1'b0, 1'b0, 8'h00, 16'h0000);
      #1;
      chk("reset read", rdata, exp_rd(8'h18 + 8'(i)));
    end
  endtask

  // write, read back with no gap, then idle
  task step(input logic [7:0] ad, input logic [15:0] d, input logic g);
    op(1'b1, 1'b0, ad, d);
    gdc <= g;
    if (ad inside {[8'h18:8'h1C]}) sh[ad - 8'h18] = d & wmask(ad);
    op(1'b0, 1'b1, ad, 16'h0000);
    #1;
    outs;
    chk("rdata idle", rdata, 16'h0000);
    op(1'b0, 1'b0, 8'h00, 16'h0000);
    #1;
    chk("rdata", rdata, exp_rd(ad));
  endtask

  initial begin
    reset_sh;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    outs;
    rd_all;
    foreach (corner[i]) step(corner[i][23:16], corner[i][15:0], i[0]);
    for (int i = 0; i < 300; i++) begin
      idx = $unsigned($random(seed)) % 7;
      a = (idx < 5) ? 8'h18 + 8'(idx) : ((idx == 5) ? 8'h17 : 8'(idx * 37));
      step(a, 16'($random(seed)), 1'($random(seed)));
    end
    @(posedge sys_clk);
    rst_b <= 1'b0;
    gdc <= 1'b0;
    @(posedge sys_clk);
    rst_b <= 1'b1;
    reset_sh;
    #1;
    outs;
    rd_all;
    give_verdict;
  end

  initial begin
    #100000;
    n_fail++;
    give_verdict;
  end
endmodule
